// *** itrc_map.svh ***
// Constants of the init and timing refinement controller: offsets, bits, counts.
// Assumes a 100 MHz system clock and byte addresses on a 32-bit register bus.
`ifndef ITRC_MAP_SVH
`define ITRC_MAP_SVH
`define ITRC_CLK_MHZ 100
`define ITRC_INTDIS_NS 200
`define ITRC_INTDIS_CYC (((`ITRC_INTDIS_NS * `ITRC_CLK_MHZ) / 1000) + 1)
`define ITRC_CMDGAP_NS 100
`define ITRC_CMDGAP_CYC (((`ITRC_CMDGAP_NS * `ITRC_CLK_MHZ) + 999) / 1000)
`define ITRC_INTDIS_TICKS 8'h04
`define ITRC_CMDGAP_TICKS 8'h02
`define ITRC_SETPULSE_TICKS 8'h04
`define ITRC_LINGER_TICKS 8'h08
`define ITRC_OFS_CTRL 8'h00
`define ITRC_OFS_OWN 8'h04
`define ITRC_OFS_PROBE 8'h08
`define ITRC_OFS_DUP 8'h0c
`define ITRC_OFS_CMD 8'h10
`define ITRC_OFS_STAT 8'h14
`define ITRC_OFS_NEXT 8'h18
`define ITRC_OFS_IRQ 8'h1c
`define ITRC_OFS_MASK 8'h20
`define ITRC_CTRL_BYPASS 0
`define ITRC_CTRL_REFINE 1
`define ITRC_CTRL_RESET 2
`define ITRC_CTRL_PSEL 6:4
`define ITRC_CTRL_RST 8'h00
`define ITRC_CMD_CLR_TXRX 8'h01
`define ITRC_CMD_CLR_FLAG 8'h02
`define ITRC_CMD_EN_TX 8'h03
`define ITRC_CMD_EN_RX 8'h04
`define ITRC_INIT_BYTE 8'hd1
`define ITRC_INIT_ADR0 11'h000
`define ITRC_INIT_ADR1 11'h001
`endif

// *** itrc_pkg.sv ***
// Types shared by the init and timing refinement controller.
// Assumes nothing beyond a SystemVerilog tool.
package itrc_pkg;
  typedef enum logic [1:0] {ITRC_IDLE, ITRC_SYNC, ITRC_WR0, ITRC_WR1} itrc_init_t;
endpackage : itrc_pkg

// *** itrc_core.sv ***
// Init sequencer, interrupt, command timing and node probe logic with an AXI4-Lite slave.
// Assumes rate_tick, tx_done and rx_done come from logic on clk; line_idle is a pin.
// Functional notes
// (R01) Bypass clear: initial RAM writes wait for an idle line.
// (R02) Bypass set: initial RAM writes proceed whatever the line does.
// (R03) Own node write stores d1 at 000h and node at 001h within 3 us.
// (R04) Host diagnostics read both bytes back and flag their absence.
// (R05) Bypass set: sequencer state decode suppresses the line wait during init.
// (R06) Refinement bit clear keeps legacy timing; set applies every refinement.
// (R07) Clear commands or next node read mask the active interrupt a while.
// (R08) Refined: interrupt mask time is fixed and exceeds 200 ns.
// (R09) Refined: prescaler select passes two synchronising flops.
// (R10) Host keeps prescaler select zero and unchanged above 5 Mbps.
// (R11) Host spaces command writes by the minimum interval.
// (R12) Refined: command interval counts system clocks, 100 ns.
// (R13) Legacy: enable commands refused while status set pulse runs.
// (R14) Refined: status bits rise at pulse end, so no refusal period.
// (R15) Receiver inhibited returning high raises an interrupt.
// (R16) Refined: probe or own node write clears stale probe and dup state.
// (R17) Refined: mask register cleared by hard and soft reset.
// (R18) Own node 00h or reset bit set gives a soft reset.
// (R19) Soft reset sets transmitter available and receiver inhibited.
`include "itrc_map.svh"
module itrc_core
  import itrc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_idle,
  input wire logic rate_tick,
  input wire logic tx_done,
  input wire logic rx_done,
  input wire logic [7:0] next_node_in,
  output logic interrupt_out_n,
  output logic ram_we,
  output logic [10:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic [2:0] prescaler_select,
  output logic tx_enable,
  output logic rx_enable,
  output logic soft_reset,
  output logic [7:0] probe_node_eff,
  output logic [7:0] dup_check_node_eff
);
  localparam logic [7:0] INTDIS_CYC = 8'(`ITRC_INTDIS_CYC);
  localparam logic [7:0] CMDGAP_CYC = 8'(`ITRC_CMDGAP_CYC);

  // Counts a timer down by one on each enabled step, stopping at zero.
  function automatic logic [7:0] cnt_step(input logic [7:0] c, input logic step);
    cnt_step = (c != 8'h00 && step) ? c - 8'h01 : c;
  endfunction : cnt_step

  logic [7:0] ctrl;
  logic [7:0] own_node_register;
  logic [7:0] probe_node_register;
  logic [7:0] dup_check_node_register;
  logic [7:0] mask;
  logic [2:0] irq_st;
  logic [1:0] stat;
  logic [1:0] stat_q;
  logic [7:0] pcnt [2];
  logic [7:0] gap;
  logic [7:0] dis;
  logic [7:0] linger;
  logic [2:0] psel_s1;
  logic [2:0] psel_s2;
  logic line_s1;
  logic line_s2;
  logic aw_full;
  logic w_full;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] wsb;
  itrc_init_t st;
  itrc_init_t next_st;

  // Bus handshake decode.
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire do_wr = aw_full & w_full & ~s_axi_bvalid;
  wire next_aw_full = (aw_full & ~do_wr) | aw_take;
  wire next_w_full = (w_full & ~do_wr) | w_take;
  wire next_bvalid = (s_axi_bvalid & ~s_axi_bready) | do_wr;
  wire next_rvalid = (s_axi_rvalid & ~s_axi_rready) | ar_take;
  wire wlo = do_wr & wsb[0];
  wire [7:0] wb = wd[7:0];
  wire wr_ctrl = wlo & (wa == `ITRC_OFS_CTRL);
  wire wr_own = wlo & (wa == `ITRC_OFS_OWN);
  wire wr_probe = wlo & (wa == `ITRC_OFS_PROBE);
  wire wr_dup = wlo & (wa == `ITRC_OFS_DUP);
  wire wr_cmd = wlo & (wa == `ITRC_OFS_CMD);
  wire wr_irq = wlo & (wa == `ITRC_OFS_IRQ);
  wire wr_mask = wlo & (wa == `ITRC_OFS_MASK);
  wire rd_next = ar_take & (s_axi_araddr == `ITRC_OFS_NEXT);
  wire wa_ok = (wa <= `ITRC_OFS_MASK) & (wa[1:0] == 2'b00);
  wire ra_ok = (s_axi_araddr <= `ITRC_OFS_MASK) & (s_axi_araddr[1:0] == 2'b00);

  // Mode bits and command decode.
  wire bypass = ctrl[`ITRC_CTRL_BYPASS];
  wire refine = ctrl[`ITRC_CTRL_REFINE];
  wire [1:0] proh = {2{~refine}} & {pcnt[1] != 8'h00, pcnt[0] != 8'h00}; // R13 R14
  wire is_en_tx = wb == `ITRC_CMD_EN_TX;
  wire is_en_rx = wb == `ITRC_CMD_EN_RX;
  wire is_clr_txrx = wb == `ITRC_CMD_CLR_TXRX;
  wire is_clr_flag = wb == `ITRC_CMD_CLR_FLAG;
  wire blocked = (is_en_tx & proh[0]) | (is_en_rx & proh[1]); // R13
  wire cmd_ok = wr_cmd & (gap == 8'h00) & ~blocked; // R11 R12
  wire cmd_bad = wr_cmd & ~cmd_ok;
  wire [1:0] en_ok = {cmd_ok & is_en_rx, cmd_ok & is_en_tx};
  wire clr_int = cmd_ok & (is_clr_txrx | is_clr_flag);
  wire dis_trig = ~interrupt_out_n & (clr_int | rd_next); // R07
  wire soft_rst = (wr_own & (wb == 8'h00)) | (wr_ctrl & wb[`ITRC_CTRL_RESET]); // R18
  wire [1:0] done = {rx_done, tx_done};
  wire init_skip_wait = bypass & (st == ITRC_SYNC); // R05

  // Sticky interrupt status: set wins over both clear paths.
  wire [2:0] irq_set = {cmd_bad, stat & ~stat_q}; // R15
  wire [2:0] irq_clr = ({3{wr_irq}} & wd[2:0])
    | {cmd_ok & is_clr_flag, {2{cmd_ok & is_clr_txrx}}};
  wire [2:0] next_irq = (irq_st & ~irq_clr) | irq_set;

  // Read data selection.
  wire [7:0] rsel =
    (s_axi_araddr == `ITRC_OFS_CTRL) ? ctrl :
    (s_axi_araddr == `ITRC_OFS_OWN) ? own_node_register :
    (s_axi_araddr == `ITRC_OFS_PROBE) ? probe_node_register :
    (s_axi_araddr == `ITRC_OFS_DUP) ? dup_check_node_register :
    (s_axi_araddr == `ITRC_OFS_STAT) ?
      {1'b0, prescaler_select, |proh, st == ITRC_IDLE, stat} :
    (s_axi_araddr == `ITRC_OFS_NEXT) ? next_node_in :
    (s_axi_araddr == `ITRC_OFS_IRQ) ? {5'h00, irq_st} :
    (s_axi_araddr == `ITRC_OFS_MASK) ? mask : 8'h00;

  // Write channel capture and response.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      wa <= 8'h00;
      wd <= 32'h0000_0000;
      wsb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (ce) begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      if (aw_take) wa <= s_axi_awaddr;
      if (w_take) wd <= s_axi_wdata;
      if (w_take) wsb <= s_axi_wstrb;
      s_axi_awready <= ~next_aw_full & ~next_bvalid;
      s_axi_wready <= ~next_w_full & ~next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (do_wr) s_axi_bresp <= wa_ok ? 2'b00 : 2'b10;
    end
  end

  // Read channel: one read at a time, data registered at the address edge.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (ce) begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take) s_axi_rdata <= {24'h00_0000, rsel};
      if (ar_take) s_axi_rresp <= ra_ok ? 2'b00 : 2'b10;
    end
  end

  // Software registers; the mask also clears on soft reset when refined.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= `ITRC_CTRL_RST;
      own_node_register <= 8'h00;
      probe_node_register <= 8'h00;
      dup_check_node_register <= 8'h00;
      mask <= 8'h00;
      irq_st <= 3'h0;
      soft_reset <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) ctrl <= wb;
      if (wr_own) own_node_register <= wb;
      if (wr_probe) probe_node_register <= wb;
      if (wr_dup) dup_check_node_register <= wb;
      if (soft_rst && refine) begin
        mask <= 8'h00; // R17
      end else if (wr_mask) begin
        mask <= wb;
      end
      irq_st <= next_irq;
      soft_reset <= soft_rst; // R18
    end
  end

  // Line idle pin synchroniser.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line_s1 <= 1'b0;
      line_s2 <= 1'b0;
    end else if (ce) begin
      line_s1 <= line_idle;
      line_s2 <= line_s1;
    end
  end

  // Init sequencer next state; the state itself is the program counter.
  always_comb begin
    next_st = st;
    case (st)
      ITRC_IDLE: if (wr_own) next_st = ITRC_SYNC;
      ITRC_SYNC: if (line_s2 || init_skip_wait) next_st = ITRC_WR0; // R01 R02
      ITRC_WR0: next_st = ITRC_WR1;
      ITRC_WR1: next_st = ITRC_IDLE;
      default: next_st = ITRC_IDLE;
    endcase
  end

  // Init sequencer: RAM writes of the marker byte and the node value.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= ITRC_IDLE;
      ram_we <= 1'b0;
      ram_addr <= 11'h000;
      ram_wdata <= 8'h00;
    end else if (ce) begin
      st <= next_st;
      ram_we <= (st == ITRC_WR0) | (st == ITRC_WR1); // R03
      ram_addr <= (st == ITRC_WR1) ? `ITRC_INIT_ADR1 : `ITRC_INIT_ADR0;
      ram_wdata <= (st == ITRC_WR1) ? own_node_register : `ITRC_INIT_BYTE;
    end
  end

  // Status bit set pulses; legacy raises the bit at pulse start, refined at its end.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat <= 2'b11;
      stat_q <= 2'b11;
      pcnt[0] <= 8'h00;
      pcnt[1] <= 8'h00;
    end else if (ce) begin
      stat_q <= stat;
      for (int i = 0; i < 2; i++) begin
        if (soft_rst) begin
          stat[i] <= 1'b1; // R19
          pcnt[i] <= 8'h00;
        end else if (done[i] && pcnt[i] == 8'h00) begin
          pcnt[i] <= `ITRC_SETPULSE_TICKS;
          if (!refine) stat[i] <= 1'b1; // R06 R13
        end else begin
          pcnt[i] <= cnt_step(pcnt[i], rate_tick);
          if (refine && pcnt[i] == 8'h01 && rate_tick) stat[i] <= 1'b1; // R14
          else if (en_ok[i]) stat[i] <= 1'b0;
        end
      end
    end
  end

  // Command interval and interrupt mask timers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap <= 8'h00;
      dis <= 8'h00;
      tx_enable <= 1'b0;
      rx_enable <= 1'b0;
    end else if (ce) begin
      if (cmd_ok) gap <= refine ? CMDGAP_CYC : `ITRC_CMDGAP_TICKS; // R06 R12
      else gap <= cnt_step(gap, refine | rate_tick);
      if (dis_trig) dis <= refine ? INTDIS_CYC : `ITRC_INTDIS_TICKS; // R07 R08
      else dis <= cnt_step(dis, refine | rate_tick);
      tx_enable <= en_ok[0];
      rx_enable <= en_ok[1];
    end
  end

  // Interrupt pin, held inactive while the mask timer runs.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      interrupt_out_n <= 1'b1;
    end else if (ce) begin
      interrupt_out_n <= ~((|(irq_st & mask[2:0])) & (dis == 8'h00) & ~dis_trig); // R07
    end
  end

  // Prescaler select; refined mode resamples it on the prescaler tick.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      psel_s1 <= 3'h0;
      psel_s2 <= 3'h0;
      prescaler_select <= 3'h0;
    end else if (ce) begin
      if (rate_tick) begin
        psel_s1 <= ctrl[`ITRC_CTRL_PSEL]; // R09
        psel_s2 <= psel_s1;
      end
      prescaler_select <= refine ? psel_s2 : ctrl[`ITRC_CTRL_PSEL]; // R06 R09
    end
  end

  // Effective probe and dup values; legacy lets old values linger a while.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      linger <= 8'h00;
      probe_node_eff <= 8'h00;
      dup_check_node_eff <= 8'h00;
    end else if (ce) begin
      if (refine && (wr_probe || wr_own)) begin
        linger <= 8'h00; // R16
        probe_node_eff <= wr_probe ? wb : probe_node_register;
        dup_check_node_eff <= 8'h00;
      end else if (refine && wr_dup) begin
        dup_check_node_eff <= wb;
      end else if (wr_probe || wr_dup) begin
        linger <= `ITRC_LINGER_TICKS;
      end else begin
        linger <= cnt_step(linger, rate_tick);
        if (linger == 8'h01 && rate_tick) begin
          probe_node_eff <= probe_node_register;
          dup_check_node_eff <= dup_check_node_register;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst || !ce);

  sequence s_wr0;
    ram_we && ram_addr == `ITRC_INIT_ADR0 && ram_wdata == `ITRC_INIT_BYTE;
  endsequence
  sequence s_wr1;
    ram_we && ram_addr == `ITRC_INIT_ADR1;
  endsequence
  property p_init_seq;
    s_wr0 |=> s_wr1;
  endproperty
  a_init_seq: assert property (p_init_seq) else $error("init second byte missing"); // R03
  property p_init_bypass;
    (wr_own && bypass && st == ITRC_IDLE) |-> ##[1:4] s_wr0;
  endproperty
  a_init_bypass: assert property (p_init_bypass) else $error("init not bypassed"); // R02 R05
  property p_init_wait;
    (st == ITRC_SYNC && !line_s2 && !bypass) |=> st == ITRC_SYNC && !ram_we;
  endproperty
  a_init_wait: assert property (p_init_wait) else $error("init ignored busy line"); // R01
  property p_intdis;
    (refine && dis_trig) |=> interrupt_out_n[*8] ##1 interrupt_out_n[*8] ##1 interrupt_out_n[*5];
  endproperty
  a_intdis: assert property (p_intdis) else $error("interrupt mask too short"); // R07 R08
  property p_cmd_gap;
    (refine && cmd_ok) |=> !cmd_ok[*8] ##1 !cmd_ok[*2];
  endproperty
  a_cmd_gap: assert property (p_cmd_gap) else $error("command interval broken"); // R12
  property p_proh;
    (wr_cmd && is_en_rx && proh[1]) |=> irq_st[2] && !rx_enable;
  endproperty
  a_proh: assert property (p_proh) else $error("enable accepted while barred"); // R13
  property p_refine_noproh;
    (refine && wr_cmd && is_en_rx && gap == 8'h00) |=> rx_enable;
  endproperty
  a_refine_noproh: assert property (p_refine_noproh) else $error("refined mode barred enable"); // R14
  property p_rx_irq;
    $rose(stat[1]) |=> irq_st[1];
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("no interrupt on receiver bit"); // R15
  property p_probe_clr;
    (refine && (wr_probe || wr_own)) |=> linger == 8'h00 && dup_check_node_eff == 8'h00;
  endproperty
  a_probe_clr: assert property (p_probe_clr) else $error("stale probe state kept"); // R16
  property p_mask_soft;
    (refine && soft_rst) |=> mask == 8'h00 && soft_reset ##1 interrupt_out_n;
  endproperty
  a_mask_soft: assert property (p_mask_soft) else $error("mask survived soft reset"); // R17
  property p_soft;
    (wr_own && wb == 8'h00) |=> soft_reset && stat == 2'b11;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset missing"); // R18 R19
endmodule : itrc_core

// *** itrc_net_model.sv ***
// Network side model: rate ticks, line activity and receive/transmit done pulses.
// Assumes the bench gives done requests as one-cycle pulses on clk.
module itrc_net_model
  import itrc_pkg::*;
#(
  parameter int TICK_DIV = 8,
  parameter logic [7:0] NEXT_NODE = 8'h2c
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic line_busy,
  input wire logic tx_req,
  input wire logic rx_req,
  output logic line_idle,
  output logic rate_tick,
  output logic tx_done,
  output logic rx_done,
  output logic [7:0] next_node_in
);
  int div_cnt;
  // The next node value is the fixed NEXT_NODE parameter.
  assign next_node_in = NEXT_NODE;
  // Divides the clock into rate ticks and registers line and done events.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= 0;
      rate_tick <= 1'b0;
      line_idle <= 1'b0;
      tx_done <= 1'b0;
      rx_done <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
      rate_tick <= (div_cnt == TICK_DIV - 1);
      line_idle <= !line_busy;
      tx_done <= tx_req;
      rx_done <= rx_req;
    end
  end
endmodule : itrc_net_model

// *** init_and_timing_refinement_ctrl_tb.sv ***
// Bench for the init and timing refinement controller over its AXI4-Lite port.
// Assumes itrc_map.svh, itrc_pkg, itrc_core and itrc_net_model are compiled first.
`include "itrc_map.svh"
module init_and_timing_refinement_ctrl_tb import itrc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, line_busy, rx_req, line_idle, rate_tick, tx_done, rx_done;
  logic int_n, ram_we, tx_en, rx_en, soft_rst;
  logic [7:0] awaddr, araddr, next_node, probe_eff, dup_eff, ram_wdata;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, last_resp;
  logic [10:0] ram_addr;
  logic [2:0] psel;
  logic [31:0] ram_log [0:15];
  int failures, check_count, cycles, rx_cnt, soft_cnt, ram_cnt, base, n, hi, tx_cnt;

  itrc_core uut (
    .clk(clk), .nrst(nrst), .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_idle(line_idle), .rate_tick(rate_tick), .tx_done(tx_done), .rx_done(rx_done),
    .next_node_in(next_node), .interrupt_out_n(int_n), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .prescaler_select(psel), .tx_enable(tx_en), .rx_enable(rx_en),
    .soft_reset(soft_rst), .probe_node_eff(probe_eff), .dup_check_node_eff(dup_eff)
  );
  itrc_net_model net (
    .clk(clk), .nrst(nrst), .line_busy(line_busy), .tx_req(1'b0), .rx_req(rx_req),
    .line_idle(line_idle), .rate_tick(rate_tick), .tx_done(tx_done), .rx_done(rx_done),
    .next_node_in(next_node)
  );

  // Free running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Logs RAM writes, counts pulses and cuts a hung run short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (ram_we === 1'b1 && ram_cnt < 16) begin
      ram_log[ram_cnt] <= {13'h0, ram_addr, ram_wdata};
      ram_cnt <= ram_cnt + 1;
    end
    if (rx_en === 1'b1) rx_cnt <= rx_cnt + 1;
    if (tx_en === 1'b1) tx_cnt <= tx_cnt + 1;
    if (soft_rst === 1'b1) soft_cnt <= soft_cnt + 1;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One AXI4-Lite write; address and data are released as each is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_on;
    logic w_on;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_on = 1'b1;
    w_on = 1'b1;
    while (aw_on || w_on) begin
      @(posedge clk);
      if (aw_on && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_on = 1'b0;
      end
      if (w_on && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_on = 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    last_resp = bresp;
    bready <= 1'b0;
  endtask : wr

  // One AXI4-Lite read.
  task automatic rd32(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge clk);
    while (arready !== 1'b1) @(posedge clk);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    d = rdata;
    last_resp = rresp;
    rready <= 1'b0;
  endtask : rd32

  // A command write followed by the host's spacing before the next one.
  task automatic cmd(input logic [7:0] c);
    wr(`ITRC_OFS_CMD, {24'h0, c});
    repeat (12) @(posedge clk);
  endtask : cmd

  // Asks the network side for one receive done pulse.
  task automatic pulse_rx();
    @(posedge clk);
    rx_req <= 1'b1;
    @(posedge clk);
    rx_req <= 1'b0;
  endtask : pulse_rx

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // Main sequence of scenarios.
  initial begin
    nrst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, rx_req} = 6'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    line_busy = 1'b1;
    {failures, check_count, cycles, rx_cnt, soft_cnt, ram_cnt, tx_cnt} = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(int_n), 32'h1);
    rd32(`ITRC_OFS_CTRL, rd);
    chk(rd, 32'h0);
    rd32(`ITRC_OFS_STAT, rd);
    chk(rd & 32'h3, 32'h3);
    rd32(8'h24, rd);
    chk({rd[31:2], last_resp}, 32'h2);
    // Initial RAM writes wait for an idle line unless bypassed.
    base = ram_cnt;
    wr(`ITRC_OFS_OWN, 32'h5a);
    chk(32'(last_resp), 32'h0);
    repeat (400) @(posedge clk);
    chk(ram_cnt - base, 0);
    line_busy <= 1'b0;
    repeat (300) @(posedge clk);
    chk(ram_log[base], {13'h0, `ITRC_INIT_ADR0, `ITRC_INIT_BYTE});
    chk(ram_log[base + 1], {13'h0, `ITRC_INIT_ADR1, 8'h5a});
    line_busy <= 1'b1;
    wr(`ITRC_OFS_CTRL, 32'h1);
    base = ram_cnt;
    wr(`ITRC_OFS_OWN, 32'h6b);
    repeat (300) @(posedge clk);
    chk(ram_log[base], {13'h0, `ITRC_INIT_ADR0, `ITRC_INIT_BYTE});
    chk(ram_log[base + 1], {13'h0, `ITRC_INIT_ADR1, 8'h6b});
    // Refined mode: prescaler select, probe clearing, command interval.
    wr(`ITRC_OFS_CTRL, 32'h52);
    repeat (24) @(posedge clk);
    chk(32'(psel), 32'h5);
    wr(`ITRC_OFS_CTRL, 32'h2);
    wr(`ITRC_OFS_DUP, 32'h44);
    wr(`ITRC_OFS_PROBE, 32'h33);
    chk({probe_eff, dup_eff}, 32'h3300);
    n = rx_cnt;
    wr(`ITRC_OFS_CMD, {24'h0, `ITRC_CMD_EN_TX});
    wr(`ITRC_OFS_CMD, {24'h0, `ITRC_CMD_EN_RX});
    repeat (12) @(posedge clk);
    cmd(`ITRC_CMD_EN_RX);
    chk(rx_cnt - n, 1);
    chk(tx_cnt, 1);
    rd32(`ITRC_OFS_IRQ, rd);
    chk(rd & 32'h4, 32'h4);
    // Refined mode: late status rise, interrupt and its disable time.
    wr(`ITRC_OFS_IRQ, 32'h7);
    wr(`ITRC_OFS_MASK, 32'h2);
    pulse_rx();
    rd32(`ITRC_OFS_STAT, rd);
    chk(rd & 32'h2, 32'h0);
    repeat (40) @(posedge clk);
    rd32(`ITRC_OFS_STAT, rd);
    chk(rd & 32'h2, 32'h2);
    chk(32'(int_n), 32'h0);
    rd32(`ITRC_OFS_NEXT, rd);
    chk(rd, 32'h2c);
    hi = 0;
    while (int_n === 1'b1 && hi < 100) begin
      @(posedge clk);
      hi++;
    end
    chk(32'(hi > 15 && hi < 26), 32'h1);
    cmd(`ITRC_CMD_CLR_FLAG);
    chk(32'(int_n), 32'h1);
    cmd(`ITRC_CMD_CLR_TXRX);
    chk(32'(int_n), 32'h1);
    wr(`ITRC_OFS_IRQ, 32'h7);
    n = rx_cnt;
    pulse_rx();
    cmd(`ITRC_CMD_EN_RX);
    chk(rx_cnt - n, 1);
    repeat (40) @(posedge clk);
    // Legacy mode: status rises at once and enables are barred meanwhile.
    wr(`ITRC_OFS_CTRL, 32'h0);
    cmd(`ITRC_CMD_EN_RX);
    n = rx_cnt;
    pulse_rx();
    rd32(`ITRC_OFS_STAT, rd);
    chk(rd & 32'h2, 32'h2);
    cmd(`ITRC_CMD_EN_RX);
    chk(rx_cnt - n, 0);
    repeat (40) @(posedge clk);
    cmd(`ITRC_CMD_EN_RX);
    chk(rx_cnt - n, 1);
    // Soft resets: mask kept in legacy mode, cleared in refined mode.
    n = soft_cnt;
    wr(`ITRC_OFS_MASK, 32'h7);
    wr(`ITRC_OFS_CTRL, 32'h4);
    repeat (2) @(posedge clk);
    chk(soft_cnt - n, 1);
    rd32(`ITRC_OFS_MASK, rd);
    chk(rd, 32'h7);
    rd32(`ITRC_OFS_STAT, rd);
    chk(rd & 32'h3, 32'h3);
    wr(`ITRC_OFS_CTRL, 32'h2);
    wr(`ITRC_OFS_CTRL, 32'h6);
    rd32(`ITRC_OFS_MASK, rd);
    chk(rd, 32'h0);
    n = soft_cnt;
    wr(`ITRC_OFS_MASK, 32'h7);
    wr(`ITRC_OFS_OWN, 32'h0);
    repeat (2) @(posedge clk);
    chk(soft_cnt - n, 1);
    rd32(`ITRC_OFS_MASK, rd);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule : init_and_timing_refinement_ctrl_tb
